// >>> bench/dwp_ctrl_model.sv
// memory controller model driving the write port pins
`timescale 1ns/100ps
`default_nettype none
module dwp_ctrl_model
  import dwp_pkg::*;
(
  input  wire logic        clock,
  output var  logic        clk_pos,
  output var  logic        clk_neg,
  output var  logic        sel_n,
  output var  logic [3:0]  addr,
  output var  logic [35:0] data,
  output var  logic [3:0]  mask_n
);
  // ---------------------------------------------------------------
  // idle pins: input clocks stand still between bursts
  // ---------------------------------------------------------------
  initial
  begin
    clk_pos = 1'b0;
    clk_neg = 1'b1;
    sel_n   = DWP_SEL_IDLE;
    addr    = 4'h0;
    data    = 36'h0;
    mask_n  = 4'hF;
  end

  // one burst, each phase nine system clocks so the pins oversample
  task automatic burst(input logic s, input logic [3:0] a, input logic [35:0] d0,
                       input logic [3:0] m0, input logic [35:0] d1, input logic [3:0] m1);
    @(negedge clock);
    // select and first beat before positive rise
    sel_n  = s;
    addr   = ~a;
    data   = d0;
    mask_n = m0;
    repeat (3) @(negedge clock);
    clk_pos = 1'b1;
    clk_neg = 1'b0;
    repeat (6) @(negedge clock);
    // write address and second beat for negative rise
    addr   = a;
    data   = d1;
    mask_n = m1;
    repeat (3) @(negedge clock);
    clk_neg = 1'b1;
    clk_pos = 1'b0;
    repeat (6) @(negedge clock);
    // released lines show garbage, not the last value
    sel_n  = 1'b1;
    addr   = ~a;
    data   = ~d1;
    mask_n = ~m1;
  endtask
endmodule
`default_nettype wire

// >>> bench/dwp_write_port_test.sv
// self-checking bench for the write port, x36 and x8 builds side by side
`timescale 1ns/100ps
`default_nettype none
module dwp_write_port_test;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  rd_addr = 4'h0;
  wire  logic  clk_pos, clk_neg, sel_n;
  wire  logic [3:0]  addr, mask_n;
  wire  logic [35:0] data, rd36;
  wire  logic [7:0]  rd8;
  wire  logic  rdy36, rdy8, done36, done8;
  logic [35:0] e36 [16];   // expected x36 array
  logic [7:0]  e8 [16];    // expected x8 array
  int          dn36 = 0;   // completion pulses seen
  int          dn8 = 0;
  int          error_cnt = 0;
  int          total_checks = 0;

  always #25 clock = ~clock;

  dwp_ctrl_model u_ctrl (.clock(clock), .clk_pos(clk_pos), .clk_neg(clk_neg),
    .sel_n(sel_n), .addr(addr), .data(data), .mask_n(mask_n));
  dwp_write_port #(.DATA_W(36), .AW(4)) uut (.clock(clock), .sys_rst(sys_rst),
    .clk_pos(clk_pos), .clk_neg(clk_neg), .write_port_select_n(sel_n), .addr(addr),
    .wr_data(data), .lane_mask_n(mask_n), .rd_addr(rd_addr), .rd_data(rd36),
    .cap_ready(rdy36), .write_done(done36));
  dwp_write_port #(.DATA_W(8), .AW(4)) uut_x8 (.clock(clock), .sys_rst(sys_rst),
    .clk_pos(clk_pos), .clk_neg(clk_neg), .write_port_select_n(sel_n), .addr(addr),
    .wr_data(data[7:0]), .lane_mask_n(mask_n), .rd_addr(rd_addr), .rd_data(rd8),
    .cap_ready(rdy8), .write_done(done8));

  // count one-cycle completion pulses so none is missed
  always @(posedge clock)
  begin
    if (done36 === 1'b1) dn36 <= dn36 + 1;
    if (done8 === 1'b1) dn8 <= dn8 + 1;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // masked lanes keep their old contents
  task automatic upd(input logic [3:0] a, input logic b, input logic [35:0] d,
                     input logic [3:0] m);
    for (int l = 0; l < 4; l++)
      if (!m[l]) e36[{a[2:0], b}][9*l +: 9] = d[9*l +: 9];
    for (int l = 0; l < 2; l++)
      if (!m[l]) e8[{a[2:0], b}][4*l +: 4] = d[4*l +: 4];
  endtask

  task automatic wr(input logic s, input logic [3:0] a, input logic [35:0] d0,
                    input logic [3:0] m0, input logic [35:0] d1, input logic [3:0] m1);
    int n36;
    int n8;
    int k;
    k = 0;
    while ((rdy36 !== 1'b1 || rdy8 !== 1'b1) && k < 200)
    begin
      @(negedge clock);
      k++;
    end
    check(36'(rdy36 & rdy8), 36'h1);
    n36 = dn36;
    n8 = dn8;
    u_ctrl.burst(s, a, d0, m0, d1, m1);
    repeat (20) @(negedge clock);
    if (!s)
    begin
      upd(a, 1'b0, d0, m0);
      upd(a, 1'b1, d1, m1);
    end
    check(36'(dn36 - n36), s ? 36'h0 : 36'h1);
    check(36'(dn8 - n8), s ? 36'h0 : 36'h1);
  endtask

  // read back every word of both arrays
  task automatic rd_all();
    for (int i = 0; i < 16; i++)
    begin
      @(negedge clock);
      rd_addr = 4'(i);
      @(negedge clock);
      check(rd36, e36[i]);
      check({28'h0, rd8}, {28'h0, e8[i]});
    end
  endtask

  function automatic logic [35:0] pat(input int a, input logic [35:0] base);
    return base ^ {4{9'(a)}};
  endfunction

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // full two-beat writes to every location
  task automatic t_fill();
    for (int a = 0; a < 8; a++)
      wr(1'b0, 4'(a), pat(a, 36'h13579BDF0), 4'h0, pat(a, 36'h2468ACE0F), 4'h0);
    rd_all();
  endtask

  // one lane on beat one, the other lanes on beat two
  task automatic t_lanes();
    for (int l = 0; l < 4; l++)
      wr(1'b0, 4'(l), pat(l, 36'hF0E1D2C3B), ~(4'h1 << l), pat(l, 36'h0A1B2C3D4), 4'h1 << l);
    rd_all();
  endtask

  // deselected burst must change nothing
  task automatic t_desel();
    wr(1'b1, 4'h2, 36'hFFFFFFFFF, 4'h0, 36'h000000000, 4'h0);
    wr(1'b1, 4'h6, 36'h5A5A5A5A5, 4'h0, 36'hA5A5A5A5A, 4'h0);
    rd_all();
  endtask

  // two writes to one place, later lanes win
  task automatic t_order();
    wr(1'b0, 4'h5, 36'h111111111, 4'hC, 36'h222222222, 4'h3);
    wr(1'b0, 4'h5, 36'h333333333, 4'h1, 36'h444444444, 4'h8);
    rd_all();
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog: the tests need under about 2000 clocks
  initial
  begin
    repeat (8000) @(posedge clock);
    error_cnt++;
    final_report();
  end

  initial
  begin
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    check(36'(done36 | done8), 36'h0);
    t_fill();
    t_lanes();
    t_desel();
    t_order();
    final_report();
  end
endmodule
`default_nettype wire

// >>> rtl/dwp_array.sv
// memory array of the write port with lane-masked word writes
`timescale 1ns/100ps
`default_nettype none
module dwp_array
  import dwp_pkg::*;
#(
  parameter int DATA_W = 36,
  parameter int LANE_W = 9,
  parameter int LANES  = 4,
  parameter int AW     = 4
)
(
  input  wire logic              clock,
  input  wire logic              wr_en,
  input  wire logic [AW-1:0]     wr_addr,
  input  wire logic [LANES-1:0]  wr_lane,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [AW-1:0]     rd_addr,
  output var  logic [DATA_W-1:0] rd_data
);
  // lanes must tile the word exactly, or a lane would be lost
  if (DATA_W != LANES * LANE_W)
  begin : g_bad_tiling
    $error("dwp_array: DATA_W must equal LANES * LANE_W");
  end

  // ---------------------------------------------------------------
  // storage, no reset: contents are undefined until written
  // ---------------------------------------------------------------
  // one storage per lane, so each lane has a single writing process
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1)
    begin : g_lane
      logic [LANE_W-1:0] mem_reg [0:(1<<AW)-1];  // this lane's words

      // masked lane keeps its contents; read data registered
      always_ff @(posedge clock)
      begin
        if (wr_en && wr_lane[g])
        begin
          mem_reg[wr_addr] <= wr_data[g*LANE_W +: LANE_W];
        end
        rd_data[g*LANE_W +: LANE_W] <= mem_reg[rd_addr];
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> rtl/dwp_pkg.sv
// package for the double-rate sram write port front end
package dwp_pkg;
  // ---------------------------------------------------------------
  // build widths
  // ---------------------------------------------------------------
  localparam int DWP_DATA_W_MAX  = 36;  // widest build data bits
  localparam int DWP_NIB_W       = 4;   // lane width on x8 build
  localparam int DWP_BYTE_W      = 9;   // lane width on other builds
  localparam int DWP_LANES_MAX   = 4;   // lanes on the widest build
  localparam int DWP_ADDR_W      = 20;  // widest write address width
  localparam int DWP_BUF_DEPTH   = 2;   // skid buffer entries
  localparam logic DWP_SEL_IDLE  = 1'b1; // select pins idle high

  // ---------------------------------------------------------------
  // one captured beat: address, beat index, data, active-high lanes
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [DWP_ADDR_W-1:0]     addr;  // write address of the burst
    logic                      beat;  // 0 first word, 1 second word
    logic [DWP_DATA_W_MAX-1:0] data;  // beat data, low bits used
    logic [DWP_LANES_MAX-1:0]  lane;  // lane write enables
  } dwp_beat_t;

  // capture sequencer states
  typedef enum logic [2:0] {
    DWP_IDLE  = 3'b001,  // waiting for select low on positive edge
    DWP_FIRST = 3'b010,  // first beat held, waiting negative edge
    DWP_HOLD  = 3'b100   // both beats held, waiting to enter buffer
  } dwp_state_t;
endpackage

// >>> rtl/dwp_write_port.sv
// double-rate sram write port: capture, lane masks, buffer, array
// ---------------------------------------------------------------
// Functional notes
// - capture data on both clock rising edges
// - active-low write select sampled on positive edge
// - select high: ignore data, no write
// - x8 build: two nibble masks, low/high
// - unselected nibble leaves stored data unchanged
// - nibble mask sampled with its data beat
// - deasserted nibble mask discards that nibble
// - byte masks cover nine-bit lanes upward
// - unselected byte lane keeps stored data
// - byte mask sampled with its data beat
// - deasserted byte mask drops nine bits
// - write address taken on negative edge
// - address ignored when port deselected
// - every access starts on positive edge
// ---------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module dwp_write_port
  import dwp_pkg::*;
#(
  parameter int DATA_W = 36,
  parameter int AW     = 4
)
(
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              clk_pos,
  input  wire logic              clk_neg,
  input  wire logic              write_port_select_n,
  input  wire logic [AW-1:0]     addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [3:0]        lane_mask_n,
  input  wire logic [AW-1:0]     rd_addr,
  output var  logic [DATA_W-1:0] rd_data,
  output var  logic              cap_ready,
  output var  logic              write_done
);
  // ---------------------------------------------------------------
  // build derived lane layout
  // ---------------------------------------------------------------
  localparam int LANE_W = (DATA_W == 8) ? DWP_NIB_W : DWP_BYTE_W;  // lane width
  localparam int LANES  = DATA_W / LANE_W;                         // lane count

  // only the four builds are served; the beat bit needs AW of 2 or more
  if (!(DATA_W == 8 || DATA_W == 9 || DATA_W == 18 || DATA_W == DWP_DATA_W_MAX))
  begin : g_bad_width
    $error("dwp_write_port: DATA_W must be 8, 9, 18 or 36");
  end
  if (AW > DWP_ADDR_W || AW < 2)
  begin : g_bad_addr
    $error("dwp_write_port: AW out of range");
  end

  // ---------------------------------------------------------------
  // input synchronisers, two flops on every pin
  // ---------------------------------------------------------------
  logic [1:0]        kp_s1_reg, kp_s2_reg;     // clock pins, stage one and two
  logic              sel_s1_reg, sel_s2_reg;   // write select sync
  logic [AW-1:0]     adr_s1_reg, adr_s2_reg;   // address sync
  logic [DATA_W-1:0] dat_s1_reg, dat_s2_reg;   // data sync
  logic [3:0]        msk_s1_reg, msk_s2_reg;   // lane mask sync
  logic [1:0]        kp_d_reg;                 // delayed clocks for edges

  // pins treated as slow strobes sampled by the system clock
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      // idle pin levels, negative clock high: no false edge after reset
      kp_s1_reg  <= 2'h2;
      kp_s2_reg  <= 2'h2;
      kp_d_reg   <= 2'h2;
      sel_s1_reg <= DWP_SEL_IDLE;
      sel_s2_reg <= DWP_SEL_IDLE;
      adr_s1_reg <= '0;
      adr_s2_reg <= '0;
      dat_s1_reg <= '0;
      dat_s2_reg <= '0;
      msk_s1_reg <= 4'hF;
      msk_s2_reg <= 4'hF;
    end
    else
    begin
      kp_s1_reg  <= {clk_neg, clk_pos};
      kp_s2_reg  <= kp_s1_reg;
      kp_d_reg   <= kp_s2_reg;
      sel_s1_reg <= write_port_select_n;
      sel_s2_reg <= sel_s1_reg;
      adr_s1_reg <= addr;
      adr_s2_reg <= adr_s1_reg;
      dat_s1_reg <= wr_data;
      dat_s2_reg <= dat_s1_reg;
      msk_s1_reg <= lane_mask_n;
      msk_s2_reg <= msk_s1_reg;
    end
  end

  // rising edges seen after synchronisation
  logic pos_edge;  // positive input clock rose
  logic neg_edge;  // negative input clock rose
  assign pos_edge = kp_s2_reg[0] & ~kp_d_reg[0];
  assign neg_edge = kp_s2_reg[1] & ~kp_d_reg[1];

  // active-high lane enables from the active-low masks
  logic [LANES-1:0] lane_en;
  assign lane_en = ~msk_s2_reg[LANES-1:0];

  // ---------------------------------------------------------------
  // capture sequencer
  // ---------------------------------------------------------------
  dwp_state_t state_reg;     // sequencer state
  dwp_beat_t  first_reg;     // first beat awaiting its address
  logic       push_ready;    // buffer took the last beat of a burst
  logic       cap_second;    // second beat seen this cycle
  logic       buf_in_ready;  // room for a beat in the buffer

  // second beat carries the write address for both beats
  assign cap_second = (state_reg == DWP_FIRST) && neg_edge;

  // state and first beat, one push per cycle so order holds
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_reg <= DWP_IDLE;
      first_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        DWP_IDLE:
        begin
          if (pos_edge && !sel_s2_reg)
          begin
            first_reg.data <= DWP_DATA_W_MAX'(dat_s2_reg);
            first_reg.lane <= DWP_LANES_MAX'(lane_en);
            first_reg.beat <= 1'b0;
            state_reg      <= DWP_FIRST;
          end
        end
        DWP_FIRST:
        begin
          if (neg_edge)
          begin
            // address on negative edge, shared by both beats
            first_reg.addr <= DWP_ADDR_W'(adr_s2_reg);
            // stash second beat behind the first
            first_reg.data <= DWP_DATA_W_MAX'(dat_s2_reg);
            first_reg.lane <= DWP_LANES_MAX'(lane_en);
            first_reg.beat <= 1'b1;
            state_reg      <= DWP_HOLD;
          end
        end
        DWP_HOLD:
        begin
          if (push_ready)
            state_reg <= DWP_IDLE;
        end
        default:
          state_reg <= DWP_IDLE;
      endcase
    end
  end
  // the stash above is overwritten by beat two before beat one leaves,
  // so beat one goes in a side register
  dwp_beat_t b0_reg;    // beat one held for the hold phase
  logic      b0_sent_reg;  // beat one already in the buffer
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      b0_reg      <= '0;
      b0_sent_reg <= 1'b0;
    end
    else
    begin
      if (cap_second)
      begin
        b0_reg      <= first_reg;
        b0_reg.addr <= DWP_ADDR_W'(adr_s2_reg);
        b0_sent_reg <= 1'b0;
      end
      else if (state_reg == DWP_HOLD && !b0_sent_reg && buf_in_ready)
        b0_sent_reg <= 1'b1;
      else if (state_reg == DWP_IDLE)
        b0_sent_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // two-entry buffer in front of the array
  // ---------------------------------------------------------------
  dwp_beat_t buf_reg [0:DWP_BUF_DEPTH-1];  // entries
  logic [1:0] cnt_reg;                     // occupancy
  logic       rd_ptr_reg, wr_ptr_reg;      // pointers
  logic       buf_in_valid;                // beat entering
  dwp_beat_t  buf_in;                      // entering beat
  logic       drain;                       // array takes head

  // beat one enters before beat two
  assign buf_in       = b0_sent_reg ? first_reg : b0_reg;
  assign buf_in_valid = (state_reg == DWP_HOLD);
  assign buf_in_ready = (cnt_reg != 2'(DWP_BUF_DEPTH));
  assign push_ready   = buf_in_ready && b0_sent_reg;
  assign drain        = (cnt_reg != 2'h0);  // array never stalls

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cnt_reg    <= 2'h0;
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
    end
    else
    begin
      if (buf_in_valid && buf_in_ready)
      begin
        buf_reg[wr_ptr_reg] <= buf_in;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (drain)
        rd_ptr_reg <= ~rd_ptr_reg;
      cnt_reg <= 2'(cnt_reg + 2'(buf_in_valid && buf_in_ready) - 2'(drain));
    end
  end

  // status outputs
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cap_ready  <= 1'b0;
      write_done <= 1'b0;
    end
    else
    begin
      cap_ready  <= (state_reg == DWP_IDLE);
      write_done <= drain && buf_reg[rd_ptr_reg].beat;
    end
  end

  // ---------------------------------------------------------------
  // array
  // ---------------------------------------------------------------
  dwp_beat_t head;
  assign head = buf_reg[rd_ptr_reg];

  dwp_array #(
    .DATA_W (DATA_W),
    .LANE_W (LANE_W),
    .LANES  (LANES),
    .AW     (AW)
  ) u_array (
    .clock   (clock),
    .wr_en   (drain),
    .wr_addr ({head.addr[AW-2:0], head.beat}),
    .wr_lane (head.lane[LANES-1:0]),
    .wr_data (head.data[DATA_W-1:0]),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_desel_no_start: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg == DWP_IDLE && pos_edge && sel_s2_reg) |=> state_reg == DWP_IDLE)
    else $error("deselected write started");
  a_sel_starts: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg == DWP_IDLE && pos_edge && !sel_s2_reg) |=> state_reg == DWP_FIRST)
    else $error("selected write not started");
  a_no_overflow: assert property (@(posedge clock) disable iff (sys_rst)
    cnt_reg <= 2'(DWP_BUF_DEPTH))
    else $error("buffer overflow");
  a_two_beats: assert property (@(posedge clock) disable iff (sys_rst)
    cap_second |=> state_reg == DWP_HOLD)
    else $error("second beat lost");
  a_beat_pair: assert property (@(posedge clock) disable iff (sys_rst)
    (drain && !head.beat) |=> (drain && head.beat))
    else $error("second beat not right behind the first");
  a_addr_shared: assert property (@(posedge clock) disable iff (sys_rst)
    (drain && head.beat) |-> head.addr == $past(head.addr))
    else $error("burst beats split across addresses");
endmodule
`default_nettype wire
